// ### hdl/p2cc_pkg.sv
// package: register map, field layout and timing constants of the port 2 alternate-function block
package p2cc_pkg;
  // ****************************************
  // register map
  // ****************************************
  // printed offset as a plain number; the bus uses the word index below
  localparam logic [15:0] P2CC_SRCSEL_ADDR = 16'hF1DA;
  localparam logic [15:0] P2CC_SRCSEL_RESET = 16'h0000;
  // printed offset 0xF1DA is not a multiple of four: keep it as an index
  localparam logic [15:0] P2CC_SRCSEL_IDX = 16'hF1DA;
  localparam logic [17:0] P2CC_SRCSEL_BYTE = {P2CC_SRCSEL_IDX, 2'b00};
  // registers of our own, word indices above the printed one
  localparam logic [15:0] P2CC_LATCH_IDX = 16'hF1E0;
  localparam logic [15:0] P2CC_DIR_IDX = 16'hF1E1;
  localparam logic [15:0] P2CC_MODE_IDX = 16'hF1E2;
  localparam logic [15:0] P2CC_EDGE_IDX = 16'hF1E3;
  localparam logic [15:0] P2CC_PIN_IDX = 16'hF1E4;
  localparam logic [15:0] P2CC_STAT_IDX = 16'hF1E5;
  localparam logic [15:0] P2CC_CLR_IDX = 16'hF1E6;
  localparam logic [15:0] P2CC_IEN_IDX = 16'hF1E7;
  localparam logic [15:0] P2CC_ZERO16 = 16'h0000;
  // ****************************************
  // timing
  // ****************************************
  localparam int P2CC_SLOW_SAMPLE_CYCLES = 8;
  localparam logic [2:0] P2CC_SLOW_LAST = 3'h7;
  // ****************************************
  // encodings
  // ****************************************
  typedef enum logic [1:0] {P2CC_SRC_PIN, P2CC_SRC_ALT, P2CC_SRC_OR, P2CC_SRC_AND} p2cc_src_t;
  typedef enum logic [1:0] {P2CC_EDGE_OFF, P2CC_EDGE_RISE, P2CC_EDGE_FALL, P2CC_EDGE_BOTH} p2cc_edge_t;
  // per line compare mode: bit0 selects mode 3 (set/clear) over mode 1 (toggle)
  localparam int P2CC_LINES = 16;
  localparam int P2CC_FAST = 8;
endpackage

// ### hdl/p2cc_port.sv
// module: port 2 capture/compare pins, fast external interrupts and timer seven input
`timescale 1ns/100ps
// Overview of operation
// - each line is capture input or compare output
// - capture path receives sampled pin input latch
// - output direction makes capture observe output latch
// - compare mode one match toggles output latch
// - mode three: match sets, overflow clears latch
// - hardware latch updates use compare trigger and overflow strobes
// - pin tristated unless direction is output
// - software may always write the output latch
// - software write beats simultaneous compare trigger
// - low lines sampled every eight cycles
// - high lines: eight-cycle capture, one-cycle fast irq
// - lines eight to fifteen give fast irq zero-seven
// - line fifteen is timer seven count input
// - fast irq edge: rising, falling or both
// - two-bit field selects alternate irq source
// - alt sources: can0, can1/scl, rtc sec, alarm, zero
module p2cc_port
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] pin_in,
  output logic [15:0] pin_out,
  output logic [15:0] pin_oe,
  input wire logic [15:0] cmp_trigger,
  input wire logic [15:0] cmp_overflow,
  output logic [15:0] capture_in,
  input wire logic can_receive_line_0,
  input wire logic can_receive_line_1,
  input wire logic rtc_second_event,
  input wire logic rtc_alarm_event,
  output logic [7:0] fast_irq_event,
  output logic timer_seven_count_in,
  output logic irq
);
  // ****************************************
  // bus decode
  // ****************************************
  logic [15:0] widx; // word index of the access
  logic wr_en; // write at access completion
  logic hit; // address maps to a register
  assign widx = paddr[17:2];
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  assign hit = (widx == p2cc_pkg::P2CC_SRCSEL_IDX) | (widx == p2cc_pkg::P2CC_LATCH_IDX)
    | (widx == p2cc_pkg::P2CC_DIR_IDX) | (widx == p2cc_pkg::P2CC_MODE_IDX)
    | (widx == p2cc_pkg::P2CC_EDGE_IDX) | (widx == p2cc_pkg::P2CC_PIN_IDX)
    | (widx == p2cc_pkg::P2CC_STAT_IDX) | (widx == p2cc_pkg::P2CC_CLR_IDX)
    | (widx == p2cc_pkg::P2CC_IEN_IDX);
  // unmapped addresses answer with an error, no state changes
  assign pslverr = psel & penable & ~hit;
  // ****************************************
  // registers
  // ****************************************
  logic [15:0] srcsel; // two bits per fast irq
  logic [15:0] out_latch; // port output latch
  logic [15:0] dir; // 1 = output
  logic [15:0] mode3; // 1 = compare mode 3, 0 = mode 1
  logic [15:0] edge_sel; // two bits per fast irq
  logic [15:0] status; // sticky fast irq events
  logic [15:0] irq_en; // interrupt enables
  logic latch_wr; // cpu write to output latch this cycle
  assign latch_wr = wr_en & (widx == p2cc_pkg::P2CC_LATCH_IDX);
  // source select register, zero at reset so pins are the default
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      srcsel <= p2cc_pkg::P2CC_SRCSEL_RESET;
    else if (wr_en && widx == p2cc_pkg::P2CC_SRCSEL_IDX)
      srcsel <= pwdata[15:0];
  end
  // configuration registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dir <= p2cc_pkg::P2CC_ZERO16;
      mode3 <= p2cc_pkg::P2CC_ZERO16;
      edge_sel <= p2cc_pkg::P2CC_ZERO16;
      irq_en <= p2cc_pkg::P2CC_ZERO16;
    end
    else if (wr_en)
    begin
      if (widx == p2cc_pkg::P2CC_DIR_IDX)
        dir <= pwdata[15:0];
      if (widx == p2cc_pkg::P2CC_MODE_IDX)
        mode3 <= pwdata[15:0];
      if (widx == p2cc_pkg::P2CC_EDGE_IDX)
        edge_sel <= pwdata[15:0];
      if (widx == p2cc_pkg::P2CC_IEN_IDX)
        irq_en <= {8'h00, pwdata[7:0]};
    end
  end
  // ****************************************
  // output latch
  // ****************************************
  // per line: cpu write wins; else mode 3 set on match, clear on
  // overflow (match wins if both); else mode 1 toggle on match
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      out_latch <= p2cc_pkg::P2CC_ZERO16;
    else
    begin
      for (int i = 0; i < p2cc_pkg::P2CC_LINES; i++)
      begin
        if (latch_wr)
          out_latch[i] <= pwdata[i];
        else if (mode3[i] && cmp_trigger[i])
          out_latch[i] <= 1'b1;
        else if (mode3[i] && cmp_overflow[i])
          out_latch[i] <= 1'b0;
        else if (!mode3[i] && cmp_trigger[i])
          out_latch[i] <= ~out_latch[i];
      end
    end
  end
  // pin drive only with output direction
  assign pin_out = out_latch;
  assign pin_oe = dir;
  // ****************************************
  // sampling
  // ****************************************
  logic [2:0] slow_cnt; // eight-cycle sample divider
  logic [15:0] in_latch; // slow sampled input latch
  logic [7:0] fast_smp; // per-cycle sample of fast lines
  logic [7:0] fast_prev; // previous combined request
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      slow_cnt <= 3'h0;
    else
      slow_cnt <= slow_cnt + 3'h1;
  end
  // capture sees the output latch when the line drives, else the pin
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      in_latch <= p2cc_pkg::P2CC_ZERO16;
    else if (slow_cnt == p2cc_pkg::P2CC_SLOW_LAST)
      in_latch <= (dir & out_latch) | (~dir & pin_in);
  end
  assign capture_in = in_latch;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fast_smp <= 8'h00;
    else
      fast_smp <= (dir[15:8] & out_latch[15:8]) | (~dir[15:8] & pin_in[15:8]);
  end
  // timer seven counts from the fast-sampled top line
  assign timer_seven_count_in = fast_smp[7];
  // ****************************************
  // fast interrupts
  // ****************************************
  logic [7:0] alt_src; // alternate request sources
  logic [7:0] req; // combined request per input
  logic [7:0] evt; // detected edges
  assign alt_src = {4'h0, rtc_alarm_event, rtc_second_event, can_receive_line_1,
    can_receive_line_0};
  always_comb
  begin
    for (int k = 0; k < p2cc_pkg::P2CC_FAST; k++)
    begin
      unique case (p2cc_pkg::p2cc_src_t'(srcsel[2*k +: 2]))
        p2cc_pkg::P2CC_SRC_PIN: req[k] = fast_smp[k];
        p2cc_pkg::P2CC_SRC_ALT: req[k] = alt_src[k];
        p2cc_pkg::P2CC_SRC_OR: req[k] = fast_smp[k] | alt_src[k];
        p2cc_pkg::P2CC_SRC_AND: req[k] = fast_smp[k] & alt_src[k];
      endcase
      unique case (p2cc_pkg::p2cc_edge_t'(edge_sel[2*k +: 2]))
        p2cc_pkg::P2CC_EDGE_OFF: evt[k] = 1'b0;
        p2cc_pkg::P2CC_EDGE_RISE: evt[k] = req[k] & ~fast_prev[k];
        p2cc_pkg::P2CC_EDGE_FALL: evt[k] = ~req[k] & fast_prev[k];
        p2cc_pkg::P2CC_EDGE_BOTH: evt[k] = req[k] ^ fast_prev[k];
      endcase
    end
  end
  // the alternate sources are assumed synchronous to pclk
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fast_prev <= 8'h00;
      fast_irq_event <= 8'h00;
    end
    else
    begin
      fast_prev <= req;
      fast_irq_event <= evt;
    end
  end
  // sticky status, a new event wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      status <= p2cc_pkg::P2CC_ZERO16;
    else if (wr_en && widx == p2cc_pkg::P2CC_CLR_IDX)
      status <= (status & ~pwdata[15:0]) | {8'h00, evt};
    else
      status <= status | {8'h00, evt};
  end
  assign irq = |(status & irq_en);
  // ****************************************
  // read data
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
    begin
      unique case (widx)
        p2cc_pkg::P2CC_SRCSEL_IDX: prdata <= {16'h0000, srcsel};
        p2cc_pkg::P2CC_LATCH_IDX: prdata <= {16'h0000, out_latch};
        p2cc_pkg::P2CC_DIR_IDX: prdata <= {16'h0000, dir};
        p2cc_pkg::P2CC_MODE_IDX: prdata <= {16'h0000, mode3};
        p2cc_pkg::P2CC_EDGE_IDX: prdata <= {16'h0000, edge_sel};
        p2cc_pkg::P2CC_PIN_IDX: prdata <= {16'h0000, in_latch};
        p2cc_pkg::P2CC_STAT_IDX: prdata <= {16'h0000, status};
        p2cc_pkg::P2CC_IEN_IDX: prdata <= {16'h0000, irq_en};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end
  // ****************************************
  // checks
  // ****************************************
  AST_SRC_RESET: assert property (@(posedge pclk) $rose(presetn) |-> srcsel == 16'h0000)
    else $error("source select not zero after reset");
  AST_TOGGLE: assert property (@(posedge pclk) disable iff (!presetn)
    (cmp_trigger[0] && !mode3[0] && !latch_wr) |=> out_latch[0] != $past(out_latch[0]))
    else $error("mode one match did not toggle");
  AST_SET: assert property (@(posedge pclk) disable iff (!presetn)
    (cmp_trigger[1] && mode3[1] && !latch_wr) |=> out_latch[1])
    else $error("mode three match did not set");
  AST_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    (cmp_overflow[1] && !cmp_trigger[1] && mode3[1] && !latch_wr) |=> !out_latch[1])
    else $error("overflow did not clear");
  AST_CPU_WINS: assert property (@(posedge pclk) disable iff (!presetn)
    (latch_wr && cmp_trigger[0]) |=> out_latch[0] == $past(pwdata[0]))
    else $error("cpu write lost to compare");
  AST_HIZ: assert property (@(posedge pclk) disable iff (!presetn)
    !dir[4] |-> !pin_oe[4])
    else $error("pin driven without output direction");
  sequence s_rise8;
    (edge_sel[1:0] == 2'b01 && srcsel[1:0] == 2'b00 && !fast_smp[0])
      ##1 (edge_sel[1:0] == 2'b01 && srcsel[1:0] == 2'b00 && fast_smp[0]);
  endsequence
  AST_RISE: assert property (@(posedge pclk) disable iff (!presetn)
    s_rise8 |=> fast_irq_event[0])
    else $error("rising edge missed");
  AST_SLOW: assert property (@(posedge pclk) disable iff (!presetn)
    slow_cnt != 3'h7 |=> $stable(in_latch))
    else $error("capture latch changed off its sample slot");
  AST_ALT: assert property (@(posedge pclk) disable iff (!presetn)
    srcsel[5:4] == 2'b01 |-> req[2] == rtc_second_event)
    else $error("alternate source not routed");
  // ****************************************
  // further checks
  // ****************************************
  // falling edge on irq zero, mode held over both samples so a mode
  // change in between cannot look like a missed edge
  sequence s_fall8;
    (edge_sel[1:0] == 2'b10 && srcsel[1:0] == 2'b00 && fast_smp[0])
      ##1 (edge_sel[1:0] == 2'b10 && srcsel[1:0] == 2'b00 && !fast_smp[0]);
  endsequence
  AST_FALL: assert property (@(posedge pclk) disable iff (!presetn)
    s_fall8 |=> fast_irq_event[0])
    else $error("falling edge missed");
  // both-edge mode: any change of the combined request gives a pulse
  // one cycle later
  AST_BOTH: assert property (@(posedge pclk) disable iff (!presetn)
    (edge_sel[1:0] == 2'b11 && req[0] != fast_prev[0]) |=> fast_irq_event[0])
    else $error("edge in both-edge mode missed");
  // detection switched off: the input must stay silent whatever the pin does
  // (this is also the reset state, so no stray pulse follows reset)
  AST_EDGE_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    edge_sel[1:0] == 2'b00 |=> !fast_irq_event[0])
    else $error("pulse with edge detection off");
  // top line, irq seven: rising edge gives a pulse
  // checks the edge detector at the far end of the range, from req[7] rather than the pin
  AST_RISE7: assert property (@(posedge pclk) disable iff (!presetn)
    (edge_sel[15:14] == 2'b01 && req[7] && !fast_prev[7]) |=> fast_irq_event[7])
    else $error("irq seven edge missed");
  // a line driven as output feeds the capture path from its own latch,
  // which is what lets software raise a capture by writing the latch
  AST_CAP_LATCH: assert property (@(posedge pclk) disable iff (!presetn)
    (slow_cnt == p2cc_pkg::P2CC_SLOW_LAST && dir[0]) |=> capture_in[0] == $past(out_latch[0]))
    else $error("capture did not see the output latch");
  // an input line feeds the capture path from the pin
  // only at the eight-cycle sample slot
  AST_CAP_PIN: assert property (@(posedge pclk) disable iff (!presetn)
    (slow_cnt == p2cc_pkg::P2CC_SLOW_LAST && !dir[8]) |=> capture_in[8] == $past(pin_in[8]))
    else $error("capture did not see the pin");
  // the sample divider wraps after eight cycles
  // so the slot comes round exactly once per eight clocks
  AST_SLOW_WRAP: assert property (@(posedge pclk) disable iff (!presetn)
    slow_cnt == p2cc_pkg::P2CC_SLOW_LAST |=> slow_cnt == 3'h0)
    else $error("sample divider did not wrap");
  // fast inputs are sampled on every clock, not on the slow slot
  // (a slow sample here would cost up to seven cycles of latency)
  AST_FAST_PIN: assert property (@(posedge pclk) disable iff (!presetn)
    !dir[8] |=> fast_smp[0] == $past(pin_in[8]))
    else $error("fast line not sampled every cycle");
  // timer seven sees the top pin one cycle after it moves
  // it shares the fast sample with irq seven
  AST_T7_PIN: assert property (@(posedge pclk) disable iff (!presetn)
    !dir[15] |=> timer_seven_count_in == $past(pin_in[15]))
    else $error("timer seven input not following the pin");
  // a cpu write always lands, whatever the compare logic does
  // covers every line at once, not only the collision case
  AST_CPU_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    latch_wr |=> out_latch == $past(pwdata[15:0]))
    else $error("cpu write to latch lost");
  // without a write, a match or an overflow the latch keeps its value
  // so nothing but the compare strobe clocks hardware changes in
  AST_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    (!latch_wr && !cmp_trigger[5] && !cmp_overflow[5]) |=> $stable(out_latch[5]))
    else $error("latch moved without a strobe");
  // mode three, match and overflow together: the match wins
  // the output then shows the newer event of the two
  AST_SET_OVER: assert property (@(posedge pclk) disable iff (!presetn)
    (cmp_trigger[1] && cmp_overflow[1] && mode3[1] && !latch_wr) |=> out_latch[1])
    else $error("match did not win over overflow");
  // source code zero: the pin alone
  // this is the reset choice, so pins work without any setup
  AST_SRC_PIN: assert property (@(posedge pclk) disable iff (!presetn)
    srcsel[1:0] == 2'b00 |-> req[0] == fast_smp[0])
    else $error("pin-only source wrong");
  // source code two: pin ored with the alternate source
  // either party can raise the request
  AST_SRC_OR: assert property (@(posedge pclk) disable iff (!presetn)
    srcsel[1:0] == 2'b10 |-> req[0] == (fast_smp[0] | can_receive_line_0))
    else $error("ored source wrong");
  // source code three: pin anded with the alternate source
  // both parties must agree before the request rises
  AST_SRC_AND: assert property (@(posedge pclk) disable iff (!presetn)
    srcsel[1:0] == 2'b11 |-> req[0] == (fast_smp[0] & can_receive_line_0))
    else $error("anded source wrong");
  // irq one takes the second receive line as its alternate
  // the same input carries the serial clock when that is in use
  AST_ALT_CAN1: assert property (@(posedge pclk) disable iff (!presetn)
    srcsel[3:2] == 2'b01 |-> req[1] == can_receive_line_1)
    else $error("second receive line not routed");
  // irqs four to seven have no alternate: it reads as zero
  // so choosing it simply silences the input
  AST_ALT_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    srcsel[9:8] == 2'b01 |-> !req[4])
    else $error("unused alternate source not zero");
  // the source register takes what software writes
  // all sixteen bits, no reserved field
  AST_SRCSEL_WR: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && widx == p2cc_pkg::P2CC_SRCSEL_IDX) |=> srcsel == $past(pwdata[15:0]))
    else $error("source select write lost");
  // a detected edge always leaves its status bit set, even when a clear
  // of the same bit falls in that cycle
  AST_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
    evt[0] |=> status[0])
    else $error("event did not set status");
  // a set status bit stays until software clears exactly that bit
  AST_STICKY_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    (status[7] && !(wr_en && widx == p2cc_pkg::P2CC_CLR_IDX && pwdata[7])) |=> status[7])
    else $error("status bit lost without a clear");
  // an enabled pending event holds the interrupt line up
  AST_IRQ_OUT: assert property (@(posedge pclk) disable iff (!presetn)
    (status[7] && irq_en[7]) |-> irq)
    else $error("enabled event did not raise irq");
endmodule

// ### verification/p2cc_pinmodel.sv
// pin-side model: external devices that drive or sense the port 2 lines
`timescale 1ns/100ps
module p2cc_pinmodel
(
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe,
  input wire logic [15:0] ext_level,
  output logic [15:0] pin_in
);
  // ****************************************
  // pin resolution
  // ****************************************
  // outside devices stay off any line the port drives, so no contention is modelled
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

// ### verification/p2cc_port_tb.sv
// testbench: register access, compare latch, capture sampling and fast interrupts
`timescale 1ns/100ps
module p2cc_port_tb;
  localparam logic [15:0] SRC = p2cc_pkg::P2CC_SRCSEL_IDX;
  localparam logic [15:0] LAT = p2cc_pkg::P2CC_LATCH_IDX;
  localparam logic [15:0] DIR = p2cc_pkg::P2CC_DIR_IDX;
  localparam logic [15:0] EDG = p2cc_pkg::P2CC_EDGE_IDX;
  localparam logic [15:0] STA = p2cc_pkg::P2CC_STAT_IDX;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, t7, err;
  logic can0, can1, rtcs, rtca;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] ext_level, pin_in, pin_out, pin_oe, cmp_trigger, cmp_overflow, capture_in;
  logic [7:0] fast_irq_event;
  int mismatches, checks_done, ev0, ev7, base;
  p2cc_port dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .cmp_trigger(cmp_trigger), .cmp_overflow(cmp_overflow), .capture_in(capture_in),
    .can_receive_line_0(can0), .can_receive_line_1(can1), .rtc_second_event(rtcs),
    .rtc_alarm_event(rtca), .fast_irq_event(fast_irq_event), .timer_seven_count_in(t7),
    .irq(irq));
  p2cc_pinmodel pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level),
    .pin_in(pin_in));
  // ****************************************
  // clock, event counters, watchdog
  // ****************************************
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // count interrupt pulses of lines 8 and 15 so edge modes can be judged
  always @(posedge pclk)
  begin
    ev0 <= ev0 + int'(fast_irq_event[0] === 1'b1);
    ev7 <= ev7 + int'(fast_irq_event[7] === 1'b1);
  end
  // the run needs about 300 cycles; a hang is cut well beyond that
  initial
  begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    results();
  end
  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one apb transfer; trig is raised in the access cycle to collide with a write
  task automatic xfer(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
    input logic [15:0] trig);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    cmp_trigger <= trig;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    cmp_trigger <= 16'h0000;
    @(negedge pclk);
  endtask
  task automatic strobe(input logic [15:0] t, input logic [15:0] o);
    @(posedge pclk);
    cmp_trigger <= t;
    cmp_overflow <= o;
    @(posedge pclk);
    cmp_trigger <= 16'h0000;
    cmp_overflow <= 16'h0000;
    repeat (2) @(posedge pclk);
  endtask
  task automatic set_pin(input logic [15:0] v);
    @(posedge pclk);
    ext_level <= v;
    repeat (5) @(posedge pclk);
  endtask
  task automatic results();
    if (mismatches == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ****************************************
  // test sequence
  // ****************************************
  initial
  begin
    {presetn, psel, penable, pwrite, can0, can1, rtcs, rtca} = 8'h00;
    {paddr, pwdata, ext_level, cmp_trigger, cmp_overflow} = '0;
    {ev0, ev7} = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, SRC, 32'h0, 16'h0);
    chk("srcsel_reset", rd, 32'h0);
    xfer(1'b1, DIR, 32'hFFFF, 16'h0);
    xfer(1'b1, LAT, 32'h00F0, 16'h0);
    chk("latch_write", pin_out, 32'h00F0);
    strobe(16'h0011, 16'h0000);
    chk("mode1_toggle", pin_out, 32'h00E1);
    xfer(1'b1, p2cc_pkg::P2CC_MODE_IDX, 32'h0002, 16'h0);
    strobe(16'h0002, 16'h0002);
    chk("mode3_set", pin_out, 32'h00E3);
    strobe(16'h0000, 16'h0002);
    chk("mode3_clear", pin_out, 32'h00E1);
    xfer(1'b1, LAT, 32'h1234, 16'h0001);
    chk("write_beats_trigger", pin_out, 32'h1234);
    repeat (20) @(posedge pclk);
    chk("capture_of_latch", capture_in, 32'h1234);
    xfer(1'b1, DIR, 32'h0, 16'h0);
    chk("tristate", pin_oe, 32'h0);
    set_pin(16'hA5C3);
    repeat (16) @(posedge pclk);
    xfer(1'b0, p2cc_pkg::P2CC_PIN_IDX, 32'h0, 16'h0);
    chk("capture_of_pin", rd, 32'hA5C3);
    chk("timer7_input", t7, 32'h1);
    set_pin(16'h0000);
    for (int m = 0; m < 4; m++)
    begin
      xfer(1'b1, EDG, m, 16'h0);
      base = ev0;
      set_pin(16'h0100);
      chk("edge_rise", ev0 - base, m % 2);
      set_pin(16'h0000);
      chk("edge_fall", ev0 - base, m % 2 + m / 2);
    end
    xfer(1'b1, EDG, 32'h4001, 16'h0);
    xfer(1'b1, p2cc_pkg::P2CC_CLR_IDX, 32'h00FF, 16'h0);
    base = ev0;
    set_pin(16'h8000);
    chk("line15_irq7", {ev7 - ev0 + base}, 32'h1);
    chk("masked_irq", irq, 32'h0);
    xfer(1'b1, p2cc_pkg::P2CC_IEN_IDX, 32'h0080, 16'h0);
    chk("enabled_irq", irq, 32'h1);
    xfer(1'b1, p2cc_pkg::P2CC_CLR_IDX, 32'h0080, 16'h0);
    chk("cleared_irq", irq, 32'h0);
    set_pin(16'h0000);
    xfer(1'b1, EDG, 32'h0001, 16'h0);
    for (int s = 0; s < 4; s++)
    begin
      xfer(1'b1, SRC, s, 16'h0);
      base = ev0;
      set_pin(16'h0000);
      can0 <= 1'b1;
      set_pin(16'h0000);
      chk("src_code", ev0 - base, (s == 1 || s == 2));
      can0 <= 1'b0;
    end
    xfer(1'b1, EDG, 32'h5555, 16'h0);
    xfer(1'b1, SRC, 32'h5555, 16'h0);
    chk("srcsel_rw", err, 32'h0);
    xfer(1'b1, p2cc_pkg::P2CC_CLR_IDX, 32'h00FF, 16'h0);
    {can0, can1, rtcs, rtca} <= 4'hF;
    set_pin(16'h0000);
    xfer(1'b0, STA, 32'h0, 16'h0);
    chk("alt_sources", rd, 32'h000F);
    xfer(1'b0, SRC, 32'h0, 16'h0);
    chk("srcsel_read", rd, 32'h5555);
    xfer(1'b0, 16'h0000, 32'h0, 16'h0);
    chk("unmapped", {err, rd[30:0]}, 32'h80000000);
    results();
  end
endmodule
